/* File: rtl/i2c_link_if.sv */
/*
 Open-drain two-wire link between the bus master and the slave device.
 Assumes each party drives only low; released lines are pulled high here.
*/
`timescale 1ns/1ns
interface i2c_link_if;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// wired-and with pull-up
	assign scl = !(scl_h_oe & !scl_h_o);
	assign sda = !((sda_h_oe & !sda_h_o) | (sda_d_oe & !sda_d_o));

	modport host (output scl_h_o, output scl_h_oe, output sda_h_o, output sda_h_oe,
		input scl, input sda);
	modport device (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface

/* File: rtl/i2c_pm_device.sv */
/*
 Slave end: serial register access plus shut-down, standby and active modes.
 Assumes the bus lines reach it through the link interface and that the
 system clock stands in for the bus-derived timing of standby.
*/
// Summary of operation
// RULE1: supply-up reset clears control and configuration
// RULE2: power-up flag set by reset, cleared on read
// RULE3: clock low over 130 ms enters shut-down
// RULE4: shut-down clears all logic and registers; the code keeps the power-up flag
// RULE5: clock high again moves to standby
// RULE6: oscillator off in standby, bus-timed logic
// RULE7: standby allows only reset/id and global control
// RULE8: chip enable set enters active, starts oscillator
// RULE9: key 0x55 at offset zero resets registers
// RULE10: answers slave address 0x65, read bit one
// RULE11: data changes only while clock low
// RULE12: one bit captured per clock high
// RULE13: start and stop detected from data edges
// RULE14: stray data edge aborts current transaction
// RULE15: bytes eight bits, msb first, then ack
// RULE16: slave pulls data low to acknowledge
// RULE17: reads continue on ack, stop on nack
// RULE18: write acked only for matching address
// RULE19: slave only, up to 400 kHz clock
// RULE20: register address byte follows, is acked
// RULE21: pointer increments after each written byte
// RULE22: pointer increments on each master read ack
// RULE23: foreign address leaves bus released until start
// RULE24: standby blocks other writes, reads give zero
`timescale 1ns/1ns
module i2c_pm_device import i2c_pm_pkg::*; #(
	parameter int SHUTDOWN_CYC = SHUTDOWN_CYC_DEF,
	parameter logic [7:0] ID_CODE = 8'h3C, // arbitrary value
	parameter int CFG_DEPTH_P = CFG_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	i2c_link_if.device link,
	output logic chip_enable_o,
	output pwr_mode_t mode_o,
	output logic power_up_flag_o
);
	localparam int CW = $clog2(SHUTDOWN_CYC + 2);
	localparam logic [CW-1:0] SD_LIM = CW'(SHUTDOWN_CYC);
	localparam int IW = $clog2(CFG_DEPTH_P);
	localparam logic [7:0] CFG_END = 8'(CFG_DEPTH_P);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_PTR = 3'b010,
		ST_WR = 3'b011,
		ST_RD = 3'b100,
		ST_WAIT = 3'b101
	} slv_state_t;

	logic scl_s;
	logic sda_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [CW-1:0] low_cnt_reg;
	logic shut_c;
	pwr_mode_t mode_reg;
	logic chip_en_reg;
	logic puf_reg;
	logic [7:0] cfg_mem [CFG_DEPTH_P];
	slv_state_t st_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic rw_reg;
	logic [7:0] ptr_reg;
	logic oe_reg;
	logic access_ok;
	logic wr_en_c;
	logic soft_rst_c;
	logic ld_c;
	logic [7:0] rd_data_c;

	// ****************************************
	// line sampling and conditions
	// ****************************************
	sync2 #(
		.W(2)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({link.scl, link.sda}),
		.q_o({scl_s, sda_s})
	);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce_i) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & !scl_q;
	assign scl_fall = !scl_s & scl_q;
	assign start_c = scl_s & scl_q & sda_q & !sda_s; // RULE13
	assign stop_c = scl_s & scl_q & !sda_q & sda_s; // RULE13

	// ****************************************
	// clock-low watch and power mode
	// ****************************************
	// this counter, the reset, the power-up flag and the slave shift, bit and rw registers survive shut-down
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_cnt_reg <= '0;
		end else if (ce_i) begin
			if (scl_s) begin
				low_cnt_reg <= '0;
			end else if (low_cnt_reg <= SD_LIM) begin
				low_cnt_reg <= low_cnt_reg + 1'b1;
			end
		end
	end

	assign shut_c = low_cnt_reg > SD_LIM; // RULE3

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= MODE_SHUT; // RULE1
		end else if (ce_i) begin
			if (shut_c) begin
				mode_reg <= MODE_SHUT; // RULE3
			end else begin
				case (mode_reg)
					MODE_SHUT: if (scl_s) mode_reg <= MODE_STBY; // RULE5
					MODE_STBY: if (chip_en_reg) mode_reg <= MODE_ACTV; // RULE8
					MODE_ACTV: if (!chip_en_reg) mode_reg <= MODE_STBY;
					default: mode_reg <= MODE_SHUT;
				endcase
			end
		end
	end

	// ****************************************
	// register file
	// ****************************************
	// standby has no internal clock: gate everything but two registers
	assign access_ok = (mode_reg == MODE_ACTV) || (ptr_reg == REG_RESET_ID)
		|| (ptr_reg == REG_GLOBAL_CTRL); // RULE6 RULE7
	assign wr_en_c = scl_fall && (bit_cnt_reg == BIT_LAST) && (st_reg == ST_WR)
		&& access_ok; // RULE24
	assign soft_rst_c = wr_en_c && (ptr_reg == REG_RESET_ID)
		&& (shift_reg == SOFT_RESET_KEY); // RULE9
	assign ld_c = scl_fall && (bit_cnt_reg == BIT_ACK)
		&& ((st_reg == ST_DEV && rw_reg == RW_READ) || st_reg == ST_RD);

	always_comb begin
		rd_data_c = '0;
		if (access_ok) begin // RULE24
			case (ptr_reg)
				REG_RESET_ID: rd_data_c = ID_CODE;
				REG_GLOBAL_CTRL: rd_data_c[CHIP_EN_BIT] = chip_en_reg;
				REG_POWER_STATUS: rd_data_c[PUF_BIT] = puf_reg;
				default: begin
					if (ptr_reg >= REG_CFG_BASE && ptr_reg < CFG_END) begin
						rd_data_c = cfg_mem[ptr_reg[IW-1:0]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			chip_en_reg <= 1'b0; // RULE1
		end else if (ce_i) begin
			if (shut_c || soft_rst_c) begin
				chip_en_reg <= 1'b0; // RULE4 RULE9
			end else if (wr_en_c && ptr_reg == REG_GLOBAL_CTRL) begin
				chip_en_reg <= shift_reg[CHIP_EN_BIT]; // RULE8
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			puf_reg <= 1'b1; // RULE2
		end else if (ce_i) begin
			if (ld_c && access_ok && ptr_reg == REG_POWER_STATUS) begin
				puf_reg <= 1'b0; // RULE2
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CFG_DEPTH_P; i++) begin
				cfg_mem[i] <= '0; // RULE1
			end
		end else if (ce_i) begin
			if (shut_c || soft_rst_c) begin
				for (int i = 0; i < CFG_DEPTH_P; i++) begin
					cfg_mem[i] <= '0; // RULE4 RULE9
				end
			end else if (wr_en_c && ptr_reg >= REG_CFG_BASE && ptr_reg < CFG_END) begin
				cfg_mem[ptr_reg[IW-1:0]] <= shift_reg;
			end
		end
	end

	// ****************************************
	// serial slave
	// ****************************************
	// data line only moves just after a seen falling clock edge
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= ST_IDLE;
			bit_cnt_reg <= '0;
			shift_reg <= '0;
			rw_reg <= 1'b0;
			ptr_reg <= '0;
			oe_reg <= 1'b0;
		end else if (ce_i) begin
			if (mode_reg == MODE_SHUT) begin
				st_reg <= ST_IDLE; // RULE4
				ptr_reg <= '0;
				oe_reg <= 1'b0;
			end else if (start_c) begin
				st_reg <= ST_DEV; // RULE14
				// the start's own clock fall wraps this to zero before the first bit
				bit_cnt_reg <= '1;
				oe_reg <= 1'b0;
			end else if (stop_c) begin
				st_reg <= ST_IDLE; // RULE14
				oe_reg <= 1'b0;
			end else if (scl_rise) begin
				if (bit_cnt_reg != BIT_ACK) begin
					if (st_reg != ST_RD) shift_reg <= {shift_reg[6:0], sda_s}; // RULE12 RULE15
				end else if (st_reg == ST_RD) begin
					if (sda_s) st_reg <= ST_WAIT; // RULE17
					else ptr_reg <= ptr_reg + 8'h01; // RULE22
				end
			end else if (scl_fall) begin
				if (bit_cnt_reg == BIT_LAST) begin
					bit_cnt_reg <= BIT_ACK;
					case (st_reg)
						ST_DEV: begin
							if (shift_reg[7:1] == DEV_ADDR) begin
								oe_reg <= 1'b1; // RULE10 RULE18
								rw_reg <= shift_reg[0];
							end else begin
								st_reg <= ST_WAIT; // RULE23
							end
						end
						ST_PTR: begin
							ptr_reg <= shift_reg; // RULE20
							oe_reg <= 1'b1;
						end
						ST_WR: oe_reg <= 1'b1; // RULE16
						ST_RD: oe_reg <= 1'b0; // RULE17
						default: oe_reg <= 1'b0;
					endcase
				end else if (bit_cnt_reg == BIT_ACK) begin
					bit_cnt_reg <= '0;
					oe_reg <= 1'b0;
					case (st_reg)
						ST_DEV: begin
							if (rw_reg == RW_READ) begin
								st_reg <= ST_RD;
								shift_reg <= rd_data_c;
								oe_reg <= !rd_data_c[7]; // RULE15
							end else begin
								st_reg <= ST_PTR;
							end
						end
						ST_PTR: st_reg <= ST_WR;
						ST_WR: ptr_reg <= ptr_reg + 8'h01; // RULE21
						ST_RD: begin
							shift_reg <= rd_data_c; // RULE17
							oe_reg <= !rd_data_c[7];
						end
						default: st_reg <= st_reg;
					endcase
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (st_reg == ST_RD) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						oe_reg <= !shift_reg[6]; // RULE11
					end
				end
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign link.sda_d_o = 1'b0;
	assign link.sda_d_oe = oe_reg;
	assign chip_enable_o = chip_en_reg;
	assign mode_o = mode_reg;
	assign power_up_flag_o = puf_reg;
endmodule

/* File: rtl/i2c_pm_host.sv */
/*
 Bus master end: runs single-byte register writes and reads on the link
 under control of wishbone-reachable registers.
 Assumes a classic wishbone master and no clock stretching by the slave.
*/
`timescale 1ns/1ns
module i2c_pm_host import i2c_pm_pkg::*; #(
	parameter int QTR_P = SCL_QTR_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	i2c_link_if.host link
);
	localparam int TW = $clog2(QTR_P);
	localparam logic [TW-1:0] TLIM = TW'(QTR_P - 1);

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_START = 2'b01,
		H_BIT = 2'b10,
		H_STOP = 2'b11
	} hst_state_t;

	typedef enum logic [1:0] {
		STEP_SLA = 2'b00,
		STEP_PTR = 2'b01,
		STEP_DAT = 2'b10,
		STEP_RX = 2'b11
	} step_t;

	logic sda_s;
	logic ack_reg;
	logic req_c;
	logic wr_c;
	logic go_c;
	logic [6:0] slave_reg;
	logic [7:0] ptr_reg;
	logic [7:0] data_reg;
	logic hold_reg;
	logic [TW-1:0] tick_reg;
	logic tick_c;
	hst_state_t hst_reg;
	step_t step_reg;
	logic [1:0] q_reg;
	logic [3:0] bitn_reg;
	logic [7:0] txb_reg;
	logic [7:0] rxb_reg;
	logic nak_reg;
	logic rd_op_reg;
	logic nack_reg;
	logic [7:0] rx_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;

	function automatic logic [7:0] tx_of(input step_t s);
		case (s)
			STEP_SLA: tx_of = {slave_reg, !RW_READ};
			STEP_PTR: tx_of = ptr_reg;
			STEP_DAT: tx_of = rd_op_reg ? {slave_reg, RW_READ} : data_reg;
			default: tx_of = '1;
		endcase
	endfunction

	sync2 #(
		.W(1)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i(link.sda),
		.q_o(sda_s)
	);

	// ****************************************
	// wishbone slave
	// ****************************************
	assign req_c = wb_cyc_i & wb_stb_i & !ack_reg;
	assign wr_c = req_c & wb_we_i & wb_sel_i[0];
	assign go_c = wr_c && wb_adr_i == HREG_CTRL
		&& (wb_dat_i[CTL_WR_BIT] || wb_dat_i[CTL_RD_BIT]);
	assign wb_ack_o = ack_reg;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else if (ce_i) begin
			ack_reg <= req_c;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			slave_reg <= DEV_ADDR;
			ptr_reg <= '0;
			data_reg <= '0;
			hold_reg <= 1'b0;
		end else if (ce_i && wr_c) begin
			case (wb_adr_i)
				HREG_SLAVE: slave_reg <= wb_dat_i[6:0];
				HREG_PTR: ptr_reg <= wb_dat_i[7:0];
				HREG_DATA: data_reg <= wb_dat_i[7:0];
				HREG_CTRL: hold_reg <= wb_dat_i[CTL_HOLD_BIT];
				default: hold_reg <= hold_reg;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (ce_i && req_c && !wb_we_i) begin
			wb_dat_o <= '0;
			case (wb_adr_i)
				HREG_SLAVE: wb_dat_o[6:0] <= slave_reg;
				HREG_PTR: wb_dat_o[7:0] <= ptr_reg;
				HREG_DATA: wb_dat_o[7:0] <= rx_reg;
				HREG_CTRL: begin
					wb_dat_o[STA_BUSY_BIT] <= hst_reg != H_IDLE;
					wb_dat_o[STA_NACK_BIT] <= nack_reg;
					wb_dat_o[CTL_HOLD_BIT] <= hold_reg;
				end
				default: wb_dat_o <= '0;
			endcase
		end
	end

	// ****************************************
	// quarter-bit timer
	// ****************************************
	assign tick_c = tick_reg == TLIM; // RULE19

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_reg <= '0;
		end else if (ce_i) begin
			if (hst_reg == H_IDLE || tick_c) tick_reg <= '0;
			else tick_reg <= tick_reg + 1'b1;
		end
	end

	// ****************************************
	// bus sequencer
	// ****************************************
	// data bits move at quarter 0 with the clock low; only start and stop move data at quarter 2 with clock high
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hst_reg <= H_IDLE;
			step_reg <= STEP_SLA;
			q_reg <= '0;
			bitn_reg <= '0;
			txb_reg <= '0;
			rxb_reg <= '0;
			nak_reg <= 1'b0;
			rd_op_reg <= 1'b0;
			nack_reg <= 1'b0;
			rx_reg <= '0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (ce_i) begin
			if (hst_reg != H_IDLE && tick_c) q_reg <= q_reg + 2'h1;
			case (hst_reg)
				H_IDLE: begin
					scl_oe_reg <= hold_reg; // long low forces slave shut-down
					sda_oe_reg <= 1'b0;
					q_reg <= '0;
					if (go_c) begin
						hst_reg <= H_START;
						rd_op_reg <= wb_dat_i[CTL_RD_BIT];
						nack_reg <= 1'b0;
						step_reg <= STEP_SLA;
					end
				end
				H_START: if (tick_c) begin // RULE13
					case (q_reg)
						2'h0: sda_oe_reg <= 1'b0;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b1;
						default: begin
							scl_oe_reg <= 1'b1;
							hst_reg <= H_BIT;
							bitn_reg <= '0;
							txb_reg <= tx_of(step_reg);
						end
					endcase
				end
				H_BIT: if (tick_c) begin
					case (q_reg)
						2'h0: sda_oe_reg <= (bitn_reg == BIT_ACK) ? 1'b0 : !txb_reg[7]; // RULE11 RULE16
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: begin
							if (bitn_reg == BIT_ACK) begin
								nak_reg <= sda_s;
							end else begin
								rxb_reg <= {rxb_reg[6:0], sda_s};
								txb_reg <= {txb_reg[6:0], 1'b1}; // RULE15
							end
						end
						default: begin
							scl_oe_reg <= 1'b1;
							if (bitn_reg != BIT_ACK) begin
								bitn_reg <= bitn_reg + 4'h1;
							end else begin
								bitn_reg <= '0;
								if (step_reg != STEP_RX && nak_reg) begin
									nack_reg <= 1'b1; // RULE18
									hst_reg <= H_STOP;
								end else begin
									case (step_reg)
										STEP_SLA: begin
											step_reg <= STEP_PTR; // RULE20
											txb_reg <= tx_of(STEP_PTR);
										end
										STEP_PTR: begin
											step_reg <= STEP_DAT;
											if (rd_op_reg) hst_reg <= H_START; // RULE10
											else txb_reg <= tx_of(STEP_DAT);
										end
										STEP_DAT: begin
											if (rd_op_reg) begin
												step_reg <= STEP_RX;
												txb_reg <= '1;
											end else begin
												hst_reg <= H_STOP;
											end
										end
										default: begin
											rx_reg <= rxb_reg; // RULE17
											hst_reg <= H_STOP;
										end
									endcase
								end
							end
						end
					endcase
				end
				H_STOP: if (tick_c) begin // RULE13
					case (q_reg)
						2'h0: sda_oe_reg <= 1'b1;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b0;
						default: hst_reg <= H_IDLE;
					endcase
				end
				default: hst_reg <= H_IDLE;
			endcase
		end
	end

	assign link.scl_h_o = 1'b0;
	assign link.scl_h_oe = scl_oe_reg;
	assign link.sda_h_o = 1'b0;
	assign link.sda_h_oe = sda_oe_reg;
endmodule

/* File: rtl/i2c_pm_pkg.sv */
/*
 Shared constants and types for the LED-driver serial slave with power-mode
 control and for the serial bus master that drives it.
 Assumes a 100 MHz system clock on both ends.
*/
package i2c_pm_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_FREQ_HZ = 100_000_000;
	localparam int SHUTDOWN_MS = 130;
	localparam int SHUTDOWN_CYC_DEF = SHUTDOWN_MS * (CLK_FREQ_HZ / 1000);
	localparam int SCL_MAX_KHZ = 400;
	localparam int SCL_QTR_CYC =
		(CLK_FREQ_HZ / 1000 + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);

	// ****************************************
	// serial protocol
	// ****************************************
	localparam logic [6:0] DEV_ADDR = 7'h65;
	localparam logic RW_READ = 1'b1;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// ****************************************
	// device register map
	// ****************************************
	localparam logic [7:0] REG_RESET_ID = 8'h00;
	localparam logic [7:0] REG_GLOBAL_CTRL = 8'h01;
	localparam logic [7:0] REG_POWER_STATUS = 8'h02;
	localparam logic [7:0] REG_CFG_BASE = 8'h03;
	localparam logic [7:0] SOFT_RESET_KEY = 8'h55;
	localparam int CHIP_EN_BIT = 0;
	localparam int PUF_BIT = 4;
	localparam int CFG_DEPTH = 16;

	typedef enum logic [1:0] {
		MODE_SHUT = 2'b00,
		MODE_STBY = 2'b01,
		MODE_ACTV = 2'b10
	} pwr_mode_t;

	// ****************************************
	// master register map (wishbone)
	// ****************************************
	localparam logic [7:0] HREG_SLAVE = 8'h00;
	localparam logic [7:0] HREG_PTR = 8'h04;
	localparam logic [7:0] HREG_DATA = 8'h08;
	localparam logic [7:0] HREG_CTRL = 8'h0C;
	localparam int CTL_WR_BIT = 0;
	localparam int CTL_RD_BIT = 1;
	localparam int CTL_HOLD_BIT = 2;
	localparam int STA_BUSY_BIT = 0;
	localparam int STA_NACK_BIT = 1;
endpackage

/* File: rtl/sync2.sv */
/*
 Two-stage synchroniser for levels entering the system clock domain.
 Assumes inputs idle high, as released bus lines do.
*/
`timescale 1ns/1ns
module sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= '1;
			q_o <= '1;
		end else if (ce_i) begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

/* File: verif/i2c_pm_link_props.sv */
/*
 Concurrent checks on the two-wire link and the slave's power-mode outputs.
 Assumes the host runs with a quarter period of 4 ref cycles, and the bench
 instantiates this beside the link interface.
*/
`timescale 1ns/1ns
module i2c_pm_link_props import i2c_pm_pkg::*; #(
	parameter int SHUTDOWN_CYC = 200
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_oe,
	input wire logic chip_enable_o,
	input pwr_mode_t mode_o,
	input wire logic power_up_flag_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// ****************************************
	// clock-low run length
	// ****************************************
	// counted on the raw line, so it never trails the slave's synchronised count
	int unsigned scl_low_cnt;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_low_cnt <= 0;
		end else if (scl) begin
			scl_low_cnt <= 0;
		end else begin
			scl_low_cnt <= scl_low_cnt + 1;
		end
	end

	// ****************************************
	// properties
	// ****************************************
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	sequence s_in_shut;
		mode_o == MODE_SHUT [*2];
	endsequence

	property p_reset_state;
		$past(rst_i) |-> !chip_enable_o && power_up_flag_o && mode_o != MODE_ACTV;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
	property p_shut_late;
		scl_low_cnt > SHUTDOWN_CYC + 8 |-> mode_o == MODE_SHUT;
	endproperty
	a_shut_late: assert property (p_shut_late) else $error("no shut-down on long low");
	property p_shut_early;
		mode_o == MODE_SHUT && $past(mode_o) != MODE_SHUT |-> scl_low_cnt > SHUTDOWN_CYC;
	endproperty
	a_shut_early: assert property (p_shut_early) else $error("shut-down too early");
	property p_shut_clears;
		s_in_shut |-> !chip_enable_o && !sda_d_oe;
	endproperty
	a_shut_clears: assert property (p_shut_clears) else $error("logic alive in shut-down");
	property p_wake;
		mode_o == MODE_SHUT && scl |-> ##[1:6] mode_o == MODE_STBY;
	endproperty
	a_wake: assert property (p_wake) else $error("no standby after clock high");
	property p_enable_active;
		$rose(chip_enable_o) |-> ##[0:2] mode_o == MODE_ACTV;
	endproperty
	a_enable_active: assert property (p_enable_active) else $error("enable without active");
	property p_dev_sda_low;
		$changed(sda_d_oe) |-> !scl;
	endproperty
	a_dev_sda_low: assert property (p_dev_sda_low) else $error("slave data moved, clock high");
	property p_start_clock;
		s_start |-> ##[1:12] !scl;
	endproperty
	a_start_clock: assert property (p_start_clock) else $error("start not followed by clock");
	property p_stop_idle;
		s_stop |=> (scl && sda) [*4];
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
	property p_scl_high;
		$rose(scl) |-> scl [*6];
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("clock high too short");
	property p_scl_low;
		$fell(scl) |-> !scl [*6];
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("clock low too short");
endmodule

/* File: verif/test_i2c_slave_power_mode_ctrl.sv */
/*
 Self-checking bench: a wishbone-driven bus master talks to the slave device.
 Assumes shortened shut-down and quarter-period parameters to keep runs short.
*/
`timescale 1ns/1ns
module test_i2c_slave_power_mode_ctrl import i2c_pm_pkg::*;;
	localparam int SHUT_P = 200;
	localparam logic [7:0] ID_P = 8'hA7; // arbitrary value
	logic ref_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc = 1'h0;
	logic wb_stb = 1'h0;
	logic wb_we = 1'h0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic chip_enable;
	pwr_mode_t mode;
	logic power_up_flag;
	int err_total = 0;
	int n_checks = 0;
	i2c_link_if link_bus();

	always #5 ref_clk_i = ~ref_clk_i;

	i2c_pm_host #(.QTR_P(4)) u_i2c_pm_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'h1),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.link(link_bus));
	i2c_pm_device #(.SHUTDOWN_CYC(SHUT_P), .ID_CODE(ID_P)) u_i2c_pm_device (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'h1), .link(link_bus),
		.chip_enable_o(chip_enable), .mode_o(mode), .power_up_flag_o(power_up_flag));
	i2c_pm_link_props #(.SHUTDOWN_CYC(SHUT_P)) u_i2c_pm_link_props (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .scl(link_bus.scl), .sda(link_bus.sda), .sda_d_oe(link_bus.sda_d_oe),
		.chip_enable_o(chip_enable), .mode_o(mode), .power_up_flag_o(power_up_flag));

	// ****************************************
	// bus tasks and checks
	// ****************************************
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] q);
		@(posedge ref_clk_i);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= dat;
		do @(posedge ref_clk_i); while (wb_ack !== 1'h1);
		q = wb_rdat;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		@(posedge ref_clk_i);
	endtask
	task automatic wb_wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb_xfer(1'h1, a, {24'h0, d}, q);
	endtask
	task automatic wb_rd(input logic [7:0] a, output logic [7:0] d);
		logic [31:0] q;
		wb_xfer(1'h0, a, 32'h0, q);
		d = q[7:0];
	endtask
	// one register transfer on the link; polls busy rather than assuming a length
	task automatic dev_op(input logic rd, input logic [7:0] ptr, input logic [7:0] d,
		output logic [7:0] q, output logic nack);
		logic [7:0] s;
		wb_wr(HREG_PTR, ptr);
		wb_wr(HREG_DATA, d);
		wb_wr(HREG_CTRL, rd ? 8'h02 : 8'h01);
		s = 8'h01;
		while (s[STA_BUSY_BIT] !== 1'h0) wb_rd(HREG_CTRL, s);
		nack = s[STA_NACK_BIT];
		wb_rd(HREG_DATA, q);
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_mode(input pwr_mode_t got, input pwr_mode_t exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: mode %b, expected %b", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_cfg(input logic active, input logic [7:0] d);
		return active ? d : 8'h00;
	endfunction
	function automatic logic [7:0] exp_status(input logic flag);
		return flag ? (8'h01 << PUF_BIT) : 8'h00;
	endfunction
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (80000) @(posedge ref_clk_i);
		err_total++;
		$display("ERROR %0t: watchdog expired", $time);
		test_done();
	end

	initial begin
		logic [7:0] q;
		logic [7:0] p;
		logic [7:0] d;
		logic nk;
		void'($urandom(32'hC282F49C));
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'h0;
		repeat (4) @(posedge ref_clk_i);
		chk_mode(mode, MODE_STBY);
		chk_val({7'h0, power_up_flag}, 8'h01);
		chk_val({7'h0, chip_enable}, 8'h00);
		wb_rd(8'h10, q);
		chk_val(q, 8'h00);
		d = 8'($urandom());
		dev_op(1'h0, REG_CFG_BASE + 8'h02, d, q, nk);
		dev_op(1'h1, REG_CFG_BASE + 8'h02, 8'h00, q, nk);
		chk_val(q, exp_cfg(1'h0, d));
		dev_op(1'h1, REG_POWER_STATUS, 8'h00, q, nk);
		chk_val(q, 8'h00);
		dev_op(1'h1, REG_RESET_ID, 8'h00, q, nk);
		chk_val(q, ID_P);
		// foreign address: must be refused and leave the device untouched
		wb_wr(HREG_SLAVE, {1'h0, DEV_ADDR ^ 7'(($urandom() % 127) + 1)});
		dev_op(1'h0, REG_GLOBAL_CTRL, 8'h01, q, nk);
		chk_val({7'h0, nk}, 8'h01);
		chk_val({7'h0, chip_enable}, 8'h00);
		wb_wr(HREG_SLAVE, {1'h0, DEV_ADDR});
		dev_op(1'h0, REG_GLOBAL_CTRL, 8'h01, q, nk);
		chk_val({7'h0, nk}, 8'h00);
		chk_mode(mode, MODE_ACTV);
		chk_val({7'h0, chip_enable}, 8'h01);
		// first and last of the bank, then random places
		for (int i = 0; i < 6; i++) begin
			p = (i == 0) ? REG_CFG_BASE : (i == 1) ? 8'h0F : REG_CFG_BASE + 8'($urandom() % 13);
			d = 8'($urandom());
			dev_op(1'h0, p, d, q, nk);
			dev_op(1'h1, p, 8'h00, q, nk);
			chk_val(q, exp_cfg(1'h1, d));
		end
		dev_op(1'h1, REG_POWER_STATUS, 8'h00, q, nk);
		chk_val(q, exp_status(1'h1));
		chk_val({7'h0, power_up_flag}, 8'h00);
		dev_op(1'h1, REG_POWER_STATUS, 8'h00, q, nk);
		chk_val(q, exp_status(1'h0));
		dev_op(1'h0, p, 8'hA5, q, nk);
		dev_op(1'h0, REG_RESET_ID, SOFT_RESET_KEY - 8'h01, q, nk);
		chk_val({7'h0, chip_enable}, 8'h01);
		dev_op(1'h0, REG_RESET_ID, SOFT_RESET_KEY, q, nk);
		chk_val({7'h0, chip_enable}, 8'h00);
		dev_op(1'h0, REG_GLOBAL_CTRL, 8'h01, q, nk);
		dev_op(1'h1, p, 8'h00, q, nk);
		chk_val(q, 8'h00);
		// leave something in the bank so the shut-down clear is visible
		dev_op(1'h0, REG_CFG_BASE, 8'h5A, q, nk);
		// short low must not shut down; the long one must
		wb_wr(HREG_CTRL, 8'h04);
		repeat (SHUT_P / 2) @(posedge ref_clk_i);
		wb_wr(HREG_CTRL, 8'h00);
		chk_mode(mode, MODE_ACTV);
		wb_wr(HREG_CTRL, 8'h04);
		repeat (SHUT_P + 20) @(posedge ref_clk_i);
		chk_mode(mode, MODE_SHUT);
		chk_val({7'h0, chip_enable}, 8'h00);
		wb_wr(HREG_CTRL, 8'h00);
		repeat (6) @(posedge ref_clk_i);
		chk_mode(mode, MODE_STBY);
		dev_op(1'h0, REG_GLOBAL_CTRL, 8'h01, q, nk);
		dev_op(1'h1, REG_CFG_BASE, 8'h00, q, nk);
		chk_val(q, 8'h00);
		test_done();
	end
endmodule
